// [rtl/prs_map.svh]
// constants for the power resource sequencer: register offsets, field positions, reset values, timing
// assumes one 10 MHz system clock; the low-power sequencer tick is derived from it
`ifndef PRS_MAP_SVH
`define PRS_MAP_SVH
`define PRS_NRES           8
`define PRS_NCLK           4
`define PRS_NTMR           2
`define PRS_TW             8
// register byte offsets
`define PRS_OFS_CTRL       12'h000
`define PRS_OFS_MIN        12'h004
`define PRS_OFS_CLKREQ     12'h008
`define PRS_OFS_ON         12'h00C
`define PRS_OFS_PEND       12'h010
`define PRS_OFS_TMRCTL     12'h014
`define PRS_OFS_DLY0       12'h020
`define PRS_OFS_DEP0       12'h040
`define PRS_OFS_CMAP0      12'h060
`define PRS_OFS_TMR0       12'h070
// control field positions
`define PRS_CTRL_PD_WL     0
`define PRS_CTRL_PD_SR     1
`define PRS_CTRL_SHDN      2
// reset values
`define PRS_CTRL_RST       32'h0000_0003
`define PRS_MIN_RST        8'h01
// low-power tick: 32768 Hz from 10 MHz, clk_sys cycles per tick rounded down
`define PRS_SYS_HZ         10000000
`define PRS_LP_HZ          32768
`define PRS_LP_DIV         (`PRS_SYS_HZ / `PRS_LP_HZ)
`define PRS_DIVW           9
`endif

// [rtl/prs_pkg.sv]
// types for the power resource sequencer
// assumes prs_map.svh is included before this package
`include "prs_map.svh"
package prs_pkg;
	typedef enum logic [1:0] {
		PRS_OFF,
		PRS_ON,
		PRS_RAMP_UP,
		PRS_RAMP_DN
	} prs_state_t;
	typedef struct packed {
		logic [`PRS_TW-1:0] on_dly;
		logic [`PRS_TW-1:0] off_dly;
	} prs_dly_t;
	typedef struct packed {
		logic wlan_rst_n;
		logic reg_en;
	} prs_pwr_t;
endpackage

// [rtl/prs_top.sv]
// power resource sequencer: dependency expansion, per-resource ramp timers, AXI4-Lite registers
// assumes request pins are asynchronous to clk_sys; one write and one read in flight at most
`timescale 1ns/100ps
`include "prs_map.svh"
module prs_top (
	input  wire logic                 clk_sys,       // 10 MHz system clock
	input  wire logic                 srst,          // synchronous reset, active high
	input  wire logic                 wlan_power_request,        // pin, async
	input  wire logic                 short_range_power_request, // pin, async
	input  wire logic [`PRS_NCLK-1:0] core_clk_req,  // clock requests from cores, async
	input  wire logic [11:0]          s_awaddr,      // write address
	input  wire logic                 s_awvalid,     // write address valid
	output logic                      s_awready,     // write address ready
	input  wire logic [31:0]          s_wdata,       // write data
	input  wire logic [3:0]           s_wstrb,       // byte strobes
	input  wire logic                 s_wvalid,      // write data valid
	output logic                      s_wready,      // write data ready
	output logic [1:0]                s_bresp,       // write response
	output logic                      s_bvalid,      // write response valid
	input  wire logic                 s_bready,      // write response ready
	input  wire logic [11:0]          s_araddr,      // read address
	input  wire logic                 s_arvalid,     // read address valid
	output logic                      s_arready,     // read address ready
	output logic [31:0]               s_rdata,       // read data
	output logic [1:0]                s_rresp,       // read response
	output logic                      s_rvalid,      // read data valid
	input  wire logic                 s_rready,      // read data ready
	output logic [`PRS_NRES-1:0]      res_on,        // resource enables
	output logic                      reg_en,        // internal regulator enable
	output logic                      wlan_rst_n,    // wlan section reset, active low
	output logic                      pd_wl_en,      // pull-down on wlan request pin
	output logic                      pd_sr_en,      // pull-down on short-range request pin
	output logic                      io_out_en      // global output enable, low in shutdown
);
	localparam int NR = `PRS_NRES;
	localparam int NC = `PRS_NCLK;
	localparam int NT = `PRS_NTMR;
	localparam int TW = `PRS_TW;

	// pin synchronisers, two flops each
	logic [NC+1:0] sync1_q;           // first stage, read only by second
	logic [NC+1:0] sync2_q;           // second stage
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
		end
		else
		begin
			sync1_q <= {core_clk_req, short_range_power_request, wlan_power_request};
			sync2_q <= sync1_q;
		end
	end
	logic wl_req;                     // synced wlan request
	logic sr_req;                     // synced short-range request
	logic [NC-1:0] clk_req;           // synced clock requests
	assign wl_req  = sync2_q[0];
	assign sr_req  = sync2_q[1];
	assign clk_req = sync2_q[NC+1:2];

	// low-power tick divider
	logic [`PRS_DIVW-1:0] div_q;      // tick prescaler
	logic                 tick_q;     // one-cycle sequencer tick
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end
		else if (div_q == `PRS_DIVW'(`PRS_LP_DIV - 1))
		begin
			div_q  <= '0;
			tick_q <= 1'b1;
		end
		else
		begin
			div_q  <= div_q + 1'b1;
			tick_q <= 1'b0;
		end
	end

	// software registers
	logic [31:0]     ctrl_q;          // pull-downs and shutdown
	logic [NR-1:0]   min_q;           // minimum_resource_mask
	logic [NR-1:0]   dep_q [NR];      // dependency table: bit j = needs j
	prs_pkg::prs_dly_t dly_q [NR];    // per-resource delays
	logic [NR-1:0]   cmap_q [NC];     // clock to resource map
	logic [NR-1:0]   tmr_mask_q [NT]; // resources named by request timers
	logic [15:0]     tmr_cnt_q [NT];  // request timer counts, active while nonzero

	// resource state
	prs_pkg::prs_state_t st_q [NR];   // four-state per resource
	logic [TW-1:0]   rt_q [NR];       // transition timer
	logic [NR-1:0]   on_q;            // resource_on_flag
	logic [NR-1:0]   pend_q;          // resource_transition_flag

	// request gathering and dependency expansion
	logic [NR-1:0] req_raw;           // direct requests
	logic [NR-1:0] req_set;           // required set after expansion
	always_comb
	begin
		req_raw = min_q;
		for (int c = 0; c < NC; c++)
			if (clk_req[c])
				req_raw = req_raw | cmap_q[c];
		for (int t = 0; t < NT; t++)
			if (tmr_cnt_q[t] != 16'h0000)
				req_raw = req_raw | tmr_mask_q[t];
		req_set = req_raw;
		// closure over the table; NR passes cover any chain length
		for (int p = 0; p < NR; p++)
			for (int r = 0; r < NR; r++)
				if (req_set[r])
					req_set = req_set | dep_q[r];
	end

	// per-resource sequencing, evaluated on each tick
	always_ff @(posedge clk_sys)
	begin
		if (srst || ctrl_q[`PRS_CTRL_SHDN])
		begin
			for (int r = 0; r < NR; r++)
			begin
				st_q[r] <= prs_pkg::PRS_OFF;
				rt_q[r] <= '0;
			end
			on_q   <= '0;
			pend_q <= '0;
		end
		else if (tick_q)
		begin
			for (int r = 0; r < NR; r++)
			begin
				logic powered_dep;                            // some dependent still on
				logic deps_on;                                // all dependencies enabled
				powered_dep = 1'b0;
				deps_on     = ((dep_q[r] & ~on_q) == '0) && ((dep_q[r] & pend_q) == '0);
				for (int k = 0; k < NR; k++)
					if (dep_q[k][r] && (on_q[k] || pend_q[k]))
						powered_dep = 1'b1;
				case (st_q[r])
					prs_pkg::PRS_RAMP_UP, prs_pkg::PRS_RAMP_DN:
					begin
						rt_q[r] <= rt_q[r] - 1'b1;
						if (rt_q[r] == TW'(1))
						begin
							pend_q[r] <= 1'b0;
							on_q[r]   <= ~on_q[r];
							st_q[r]   <= (st_q[r] == prs_pkg::PRS_RAMP_UP) ?
								prs_pkg::PRS_ON : prs_pkg::PRS_OFF;
						end
					end
					prs_pkg::PRS_ON:
						if (!req_set[r] && !powered_dep)
						begin
							if (dly_q[r].off_dly == '0)
							begin
								on_q[r] <= 1'b0;
								st_q[r] <= prs_pkg::PRS_OFF;
							end
							else
							begin
								rt_q[r]   <= dly_q[r].off_dly;
								pend_q[r] <= 1'b1;
								st_q[r]   <= prs_pkg::PRS_RAMP_DN;
							end
						end
					prs_pkg::PRS_OFF:
						if (req_set[r] && deps_on)
						begin
							if (dly_q[r].on_dly == '0)
							begin
								on_q[r] <= 1'b1;
								st_q[r] <= prs_pkg::PRS_ON;
							end
							else
							begin
								rt_q[r]   <= dly_q[r].on_dly;
								pend_q[r] <= 1'b1;
								st_q[r]   <= prs_pkg::PRS_RAMP_UP;
							end
						end
					default:
						st_q[r] <= prs_pkg::PRS_OFF;
				endcase
			end
		end
	end

	// request timers count down on ticks
	logic        tmr_wr_go;           // write hits a request timer count
	logic        tmr_wr_idx;          // which timer
	logic [15:0] tmr_wr_val;          // value written
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			for (int t = 0; t < NT; t++)
				tmr_cnt_q[t] <= '0;
		else if (tmr_wr_go)
			tmr_cnt_q[tmr_wr_idx] <= tmr_wr_val;
		else if (tick_q)
			for (int t = 0; t < NT; t++)
				if (tmr_cnt_q[t] != 16'h0000)
					tmr_cnt_q[t] <= tmr_cnt_q[t] - 1'b1;
	end

	// pin outputs, all registered
	prs_pkg::prs_pwr_t pwr_q;         // regulator and wlan reset
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			pwr_q     <= '0;
			res_on    <= '0;
			pd_wl_en  <= 1'b1;
			pd_sr_en  <= 1'b1;
			io_out_en <= 1'b0;
		end
		else
		begin
			pwr_q.reg_en     <= wl_req | sr_req;
			pwr_q.wlan_rst_n <= wl_req;
			res_on    <= on_q;
			pd_wl_en  <= ctrl_q[`PRS_CTRL_PD_WL];
			pd_sr_en  <= ctrl_q[`PRS_CTRL_PD_SR];
			io_out_en <= ~ctrl_q[`PRS_CTRL_SHDN];
		end
	end
	assign reg_en     = pwr_q.reg_en;
	assign wlan_rst_n = pwr_q.wlan_rst_n;

	// axi write: take address and data in either order, answer one cycle after both
	logic [11:0] aw_q;                // captured address
	logic [31:0] wd_q;                // captured data
	logic        wr_go;               // both halves present
	assign wr_go      = !s_awready && !s_wready && !s_bvalid; // a low ready means that half is held
	assign tmr_wr_idx = aw_q[3];
	assign tmr_wr_val = wd_q[15:0];
	assign tmr_wr_go  = wr_go && (aw_q[11:4] == `PRS_OFS_TMR0 >> 4) && (aw_q[2] == 1'b0);
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			s_awready <= 1'b1;                            // ready in reset is harmless: valid is low there
			s_wready  <= 1'b1;
			aw_q      <= '0;
			wd_q      <= '0;
			s_bvalid  <= 1'b0;
			s_bresp   <= 2'b00;
		end
		else
		begin
			if (s_awvalid && s_awready)
			begin
				s_awready <= 1'b0;                        // hold the address until the answer
				aw_q      <= s_awaddr;
			end
			if (s_wvalid && s_wready)
			begin
				s_wready <= 1'b0;
				wd_q     <= s_wdata;                          // strobes ignored; full-word registers
			end
			if (wr_go)
			begin
				s_awready <= 1'b1;
				s_wready  <= 1'b1;
				s_bvalid  <= 1'b1;
				s_bresp   <= wr_hit(aw_q) ? 2'b00 : 2'b10;
			end
			else if (s_bvalid && s_bready)
				s_bvalid <= 1'b0;
		end
	end
	// address decode for writable registers
	function automatic logic wr_hit(input logic [11:0] a);
		wr_hit = (a == `PRS_OFS_CTRL) || (a == `PRS_OFS_MIN) ||
			((a >= `PRS_OFS_DLY0) && (a < `PRS_OFS_DLY0 + 12'h020)) ||
			((a >= `PRS_OFS_DEP0) && (a < `PRS_OFS_DEP0 + 12'h020)) ||
			((a >= `PRS_OFS_CMAP0) && (a < `PRS_OFS_CMAP0 + 12'h010)) ||
			((a >= `PRS_OFS_TMR0) && (a < `PRS_OFS_TMR0 + 12'h010));
	endfunction

	// register storage
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			ctrl_q <= `PRS_CTRL_RST;
			min_q  <= `PRS_MIN_RST;
			for (int r = 0; r < NR; r++)
			begin
				dly_q[r] <= '0;
				dep_q[r] <= '0;
			end
			for (int c = 0; c < NC; c++)
				cmap_q[c] <= '0;
			for (int t = 0; t < NT; t++)
				tmr_mask_q[t] <= '0;
		end
		else if (wr_go)
		begin
			if (aw_q == `PRS_OFS_CTRL)
				ctrl_q <= {29'h0, wd_q[2:0]};
			if (aw_q == `PRS_OFS_MIN)
				min_q <= wd_q[NR-1:0];
			if (aw_q[11:5] == `PRS_OFS_DLY0 >> 5)
				dly_q[aw_q[4:2]] <= wd_q[2*TW-1:0];
			if (aw_q[11:5] == `PRS_OFS_DEP0 >> 5)
				dep_q[aw_q[4:2]] <= wd_q[NR-1:0];
			if (aw_q[11:4] == `PRS_OFS_CMAP0 >> 4)
				cmap_q[aw_q[3:2]] <= wd_q[NR-1:0];
			if ((aw_q[11:4] == `PRS_OFS_TMR0 >> 4) && aw_q[2])
				tmr_mask_q[aw_q[3]] <= wd_q[NR-1:0];
		end
	end

	// axi read: answer on the same edge that takes the address
	logic [31:0] rd_mux;              // read data selection
	logic        rd_ok;               // mapped address
	always_comb
	begin
		rd_mux = '0;
		rd_ok  = 1'b1;
		if (s_araddr == `PRS_OFS_CTRL)
			rd_mux = ctrl_q;
		else if (s_araddr == `PRS_OFS_MIN)
			rd_mux = {24'h0, min_q};
		else if (s_araddr == `PRS_OFS_CLKREQ)
			rd_mux = {28'h0, clk_req};
		else if (s_araddr == `PRS_OFS_ON)
			rd_mux = {24'h0, on_q};
		else if (s_araddr == `PRS_OFS_PEND)
			rd_mux = {24'h0, pend_q};
		else if (s_araddr == `PRS_OFS_TMRCTL)
			rd_mux = {28'h0, reg_en, wlan_rst_n, sr_req, wl_req};
		else if (s_araddr[11:5] == `PRS_OFS_DLY0 >> 5)
			rd_mux = {16'h0, dly_q[s_araddr[4:2]]};
		else if (s_araddr[11:5] == `PRS_OFS_DEP0 >> 5)
			rd_mux = {24'h0, dep_q[s_araddr[4:2]]};
		else if (s_araddr[11:4] == `PRS_OFS_CMAP0 >> 4)
			rd_mux = {24'h0, cmap_q[s_araddr[3:2]]};
		else if (s_araddr[11:4] == `PRS_OFS_TMR0 >> 4)
			rd_mux = s_araddr[2] ? {24'h0, tmr_mask_q[s_araddr[3]]} : {16'h0, tmr_cnt_q[s_araddr[3]]};
		else
			rd_ok = 1'b0;
	end
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			s_arready <= 1'b1;
			s_rvalid  <= 1'b0;
			s_rdata   <= '0;
			s_rresp   <= 2'b00;
		end
		else if (s_arvalid && s_arready)
		begin
			s_arready <= 1'b0;                            // one read in flight at most
			s_rvalid  <= 1'b1;
			s_rdata   <= rd_mux;
			s_rresp   <= rd_ok ? 2'b00 : 2'b10;
		end
		else if (s_rvalid && s_rready)
		begin
			s_arready <= 1'b1;
			s_rvalid  <= 1'b0;
		end
	end

	// a ramp finishing must flip the on flag and clear its transition flag together
	ramp_end_a: assert property (@(posedge clk_sys) disable iff (srst)
		(tick_q && pend_q[1] && rt_q[1] == TW'(1) && !ctrl_q[`PRS_CTRL_SHDN]) |=> (!pend_q[1] && on_q[1] != $past(on_q[1])))
		else $error("ramp end did not settle resource 1");
	timer_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
		(pend_q[1] == (rt_q[1] != '0)))
		else $error("timer and transition flag disagree");
	reg_or_a: assert property (@(posedge clk_sys) disable iff (srst)
		##1 (reg_en == $past(wl_req | sr_req)))
		else $error("regulator enable not the OR of requests");
	wlan_rst_a: assert property (@(posedge clk_sys) disable iff (srst)
		##1 (wlan_rst_n == $past(wl_req)))
		else $error("wlan reset not following request");
	no_early_on_a: assert property (@(posedge clk_sys) disable iff (srst)
		($rose(on_q[0]) && $past(st_q[0]) == prs_pkg::PRS_OFF) |-> $past(req_set[0]))
		else $error("resource turned on without request");
	no_early_off_a: assert property (@(posedge clk_sys) disable iff (srst)
		(tick_q && st_q[0] == prs_pkg::PRS_ON && req_set[0] && !ctrl_q[`PRS_CTRL_SHDN]) |=> on_q[0])
		else $error("requested resource turned off");
	shdn_io_a: assert property (@(posedge clk_sys) disable iff (srst)
		ctrl_q[`PRS_CTRL_SHDN] |=> (!io_out_en && on_q == '0))
		else $error("outputs still enabled in shutdown");
	min_req_a: assert property (@(posedge clk_sys) disable iff (srst)
		(tick_q && min_q[0] && st_q[0] == prs_pkg::PRS_OFF && dep_q[0] == '0 && !ctrl_q[`PRS_CTRL_SHDN])
		|=> (st_q[0] != prs_pkg::PRS_OFF))
		else $error("minimum resource not started");
endmodule

// [verif/prs_host.sv]
// host model: drives the wlan and short-range power request pins
// assumes commands arrive from the bench in the clk_sys domain
`timescale 1ns/100ps
module prs_host (
	input  wire logic clk_sys,                   // system clock
	input  wire logic srst,                      // sync reset, active high
	input  wire logic wl_cmd,                    // host wants wlan power
	input  wire logic sr_cmd,                    // host wants short-range power
	output logic      wlan_power_request,        // pin into the device
	output logic      short_range_power_request  // pin into the device
);
	// pins follow commands one edge late; both low is the only way to drop the regulators
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			wlan_power_request        <= 1'b0;
			short_range_power_request <= 1'b0;
		end
		else
		begin
			wlan_power_request        <= wl_cmd;
			short_range_power_request <= sr_cmd;
		end
	end
endmodule

// [verif/tb_prs_top.sv]
// self-checking bench for the power resource sequencer
// assumes the tick is 305 clk_sys cycles and ramps are counted in ticks
`timescale 1ns/100ps
`include "prs_map.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
	$display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb_prs_top;
	localparam int TK = `PRS_LP_DIV;   // clk_sys cycles per sequencer tick
	logic        clk_sys = 1'b0;       // 10 MHz
	logic        srst = 1'b1;          // sync reset
	logic        wl_cmd = 1'b0;        // host command, wlan
	logic        sr_cmd = 1'b0;        // host command, short-range
	logic        wl_pin, sr_pin;       // request pins
	logic [3:0]  core_clk_req = 4'h0;  // core clock demands
	logic [11:0] s_awaddr = 12'h000, s_araddr = 12'h000;
	logic [31:0] s_wdata = 32'h0, s_rdata;
	logic [3:0]  s_wstrb = 4'hF;
	logic        s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
	logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [1:0]  s_bresp, s_rresp;
	logic [7:0]  res_on;               // resource on flags
	logic        reg_en, wlan_rst_n, pd_wl_en, pd_sr_en, io_out_en;
	int          errors = 0, checks = 0, cyc = 0, t0, c, bad;
	logic [31:0] d;                    // read data scratch
	logic [1:0]  r;                    // read response scratch
	always #50 clk_sys = ~clk_sys;
	// free cycle count for timing windows
	always @(posedge clk_sys) cyc <= cyc + 1;
	prs_host host (.clk_sys(clk_sys), .srst(srst), .wl_cmd(wl_cmd), .sr_cmd(sr_cmd),
		.wlan_power_request(wl_pin), .short_range_power_request(sr_pin));
	prs_top uut (.clk_sys(clk_sys), .srst(srst), .wlan_power_request(wl_pin),
		.short_range_power_request(sr_pin), .core_clk_req(core_clk_req),
		.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
		.s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
		.s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
		.s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
		.s_rready(s_rready), .res_on(res_on), .reg_en(reg_en), .wlan_rst_n(wlan_rst_n),
		.pd_wl_en(pd_wl_en), .pd_sr_en(pd_sr_en), .io_out_en(io_out_en));
	// verdict, also reached from any expired wait
	task report_and_stop;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// one write; halves released as each is taken, response checked
	task automatic axw(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
		logic ap, wp;
		@(posedge clk_sys);
		ap = 1'b1;
		wp = 1'b1;
		s_awaddr <= a; s_wdata <= v; s_awvalid <= 1'b1; s_wvalid <= 1'b1; s_bready <= 1'b1;
		for (int n = 0; n < 100; n++)
		begin
			@(posedge clk_sys);
			if (ap && s_awready) begin ap = 1'b0; s_awvalid <= 1'b0; end
			if (wp && s_wready) begin wp = 1'b0; s_wvalid <= 1'b0; end
			if (s_bvalid)
			begin
				s_bready <= 1'b0;
				`CHK("bresp", er, s_bresp)
				return;
			end
		end
		errors++;
		report_and_stop;
	endtask
	// one read; data and response taken at the rvalid edge
	task automatic axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rr);
		logic ap;
		@(posedge clk_sys);
		ap = 1'b1;
		s_araddr <= a; s_arvalid <= 1'b1; s_rready <= 1'b1;
		for (int n = 0; n < 100; n++)
		begin
			@(posedge clk_sys);
			if (ap && s_arready) begin ap = 1'b0; s_arvalid <= 1'b0; end
			if (s_rvalid)
			begin
				v = s_rdata;
				rr = s_rresp;
				s_rready <= 1'b0;
				return;
			end
		end
		errors++;
		report_and_stop;
	endtask
	// bounded wait for a resource flag; counts dependency violations of 3 on 4
	task automatic wait_res(input int i, input logic v);
		for (c = 0; c < 3000; c++)
		begin
			@(posedge clk_sys);
			if (res_on[3] === 1'b1 && res_on[4] !== 1'b1) bad++;
			if (res_on[i] === v) return;
		end
		errors++;
		report_and_stop;
	endtask
	// reset values, then clear every delay and dependency
	task t_reset;
		`CHK("res_on", 8'h00, res_on)
		`CHK("pd_wl", 1'b1, pd_wl_en)
		`CHK("pd_sr", 1'b1, pd_sr_en)
		axr(`PRS_OFS_CTRL, d, r);
		`CHK("ctrl", 32'h0000_0003, d)
		axr(`PRS_OFS_MIN, d, r);
		`CHK("min", 32'h0000_0001, d)
		axr(`PRS_OFS_PEND, d, r);
		`CHK("pend", 32'h0000_0000, d)
		`CHK("io_en", 1'b1, io_out_en)
		for (int k = 0; k < 8; k++)
		begin
			axw(`PRS_OFS_DLY0 + 12'(4 * k), 32'h0, 2'b00);
			axw(`PRS_OFS_DEP0 + 12'(4 * k), 32'h0, 2'b00);
		end
		wait_res(0, 1'b1);
		`CHK("res0", 1'b1, res_on[0])
		axr(`PRS_OFS_ON, d, r);
		`CHK("on_flags", 32'h0000_0001, d)
		$display("test reset done");
	endtask
	// every pin combination, both low last
	task t_pins;
		for (int k = 0; k < 4; k++)
		begin
			wl_cmd <= k[0];
			sr_cmd <= k[1];
			repeat (6) @(posedge clk_sys);
			`CHK("reg_en", k[0] | k[1], reg_en)
			`CHK("wlan_rst_n", k[0], wlan_rst_n)
			axr(`PRS_OFS_TMRCTL, d, r);
			`CHK("status", ({k[0] | k[1], k[0], k[1], k[0]}), d[3:0])
		end
		wl_cmd <= 1'b0;
		sr_cmd <= 1'b0;
		repeat (6) @(posedge clk_sys);
		`CHK("reg_off", 1'b0, reg_en)
		$display("test pins done");
	endtask
	// pull-downs off by software, unmapped place refused
	task t_pd;
		axw(`PRS_OFS_CTRL, 32'h0, 2'b00);
		repeat (2) @(posedge clk_sys);
		`CHK("pd_wl", 1'b0, pd_wl_en)
		`CHK("pd_sr", 1'b0, pd_sr_en)
		axw(`PRS_OFS_CTRL, 32'h3, 2'b00);
		axr(12'hFFC, d, r);
		`CHK("rresp", 2'b10, r)
		`CHK("rdata", 32'h0, d)
		axw(12'hFFC, 32'h5A, 2'b10);
		$display("test pulldown done");
	endtask
	// timed ramps, then zero delays
	task t_ramp;
		axw(`PRS_OFS_DLY0 + 12'h004, 32'h0000_0302, 2'b00);
		axw(`PRS_OFS_MIN, 32'h3, 2'b00);
		t0 = cyc;
		repeat (400) @(posedge clk_sys);
		axr(`PRS_OFS_PEND, d, r);
		`CHK("pend1", 1'b1, d[1])
		`CHK("ramping", 1'b0, res_on[1])
		wait_res(1, 1'b1);
		`CHK("on_time", 1'b1, (cyc - t0 > 2 * TK) && (cyc - t0 <= 5 * TK))
		axr(`PRS_OFS_PEND, d, r);
		`CHK("pend_clr", 1'b0, d[1])
		axw(`PRS_OFS_MIN, 32'h1, 2'b00);
		t0 = cyc;
		wait_res(1, 1'b0);
		`CHK("off_time", 1'b1, (cyc - t0 > TK) && (cyc - t0 <= 4 * TK))
		axw(`PRS_OFS_MIN, 32'h5, 2'b00);
		t0 = cyc;
		wait_res(2, 1'b1);
		`CHK("on_now", 1'b1, cyc - t0 <= 2 * TK)
		axw(`PRS_OFS_MIN, 32'h1, 2'b00);
		t0 = cyc;
		wait_res(2, 1'b0);
		`CHK("off_now", 1'b1, cyc - t0 <= 2 * TK)
		$display("test ramp done");
	endtask
	// resource 3 needs 4: on after it, off before it
	task t_dep;
		bad = 0;
		axw(`PRS_OFS_DEP0 + 12'h00C, 32'h10, 2'b00);
		axw(`PRS_OFS_DLY0 + 12'h010, 32'h0000_0400, 2'b00);
		axw(`PRS_OFS_DLY0 + 12'h00C, 32'h0000_0003, 2'b00);
		axw(`PRS_OFS_MIN, 32'h9, 2'b00);
		wait_res(3, 1'b1);
		`CHK("dep_on", 0, bad)
		`CHK("dep4", 1'b1, res_on[4])
		axw(`PRS_OFS_MIN, 32'h1, 2'b00);
		wait_res(4, 1'b0);
		`CHK("dep_off", 0, bad)
		`CHK("dep3", 1'b0, res_on[3])
		$display("test dependency done");
	endtask
	// clock demand and request timer as sources
	task t_src;
		axw(`PRS_OFS_CMAP0, 32'h20, 2'b00);
		core_clk_req <= 4'h1;
		wait_res(5, 1'b1);
		`CHK("clk_res", 1'b1, res_on[5])
		axr(`PRS_OFS_CLKREQ, d, r);
		`CHK("clk_req", 32'h0000_0001, d)
		core_clk_req <= 4'h0;
		wait_res(5, 1'b0);
		`CHK("clk_drop", 1'b0, res_on[5])
		axw(`PRS_OFS_TMR0 + 12'h004, 32'h40, 2'b00);
		axw(`PRS_OFS_TMR0, 32'h3, 2'b00);
		wait_res(6, 1'b1);
		`CHK("tmr_res", 1'b1, res_on[6])
		wait_res(6, 1'b0);
		`CHK("tmr_end", 1'b0, res_on[6])
		$display("test sources done");
	endtask
	// shutdown drops io_out_en, res_on and the transition flags; leaving it brings io_out_en back
	task t_shdn;
		axw(`PRS_OFS_CTRL, 32'h7, 2'b00);
		repeat (4) @(posedge clk_sys);
		`CHK("io_off", 1'b0, io_out_en)
		`CHK("res_off", 8'h00, res_on)
		axr(`PRS_OFS_PEND, d, r);
		`CHK("pend_off", 32'h0, d)
		axw(`PRS_OFS_CTRL, 32'h3, 2'b00);
		repeat (4) @(posedge clk_sys);
		`CHK("io_back", 1'b1, io_out_en)
		$display("test shutdown done");
	endtask
	// main sequence
	initial
	begin
		repeat (4) @(posedge clk_sys);
		srst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		t_reset;
		t_pins;
		t_pd;
		t_ramp;
		t_dep;
		t_src;
		t_shdn;
		report_and_stop;
	end
endmodule
